// >>> rtc_pkg.sv
`default_nettype none

package rtc_pkg;

  // ----------------------------------------------------------------
  // clocks and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SPIKE_NS = 50;
  localparam int unsigned FILT_CYC_RAW = (SPIKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FILT_CYC = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
  localparam int unsigned OSC_HZ = 32_768;
  localparam int unsigned SCL_MAX_HZ = 400_000;

  // ----------------------------------------------------------------
  // serial bus slave address, value arbitrary
  // ----------------------------------------------------------------
  localparam logic [6:0] I2C_ADDR = 7'h29;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_SEC = 4'h0;
  localparam logic [3:0] REG_MIN = 4'h1;
  localparam logic [3:0] REG_HOUR = 4'h2;
  localparam logic [3:0] REG_WDAY = 4'h3;
  localparam logic [3:0] REG_DAY = 4'h4;
  localparam logic [3:0] REG_MON = 4'h5;
  localparam logic [3:0] REG_YEAR = 4'h6;
  localparam logic [3:0] REG_ADJ = 4'h7;
  localparam logic [3:0] REG_WA_MIN = 4'h8;
  localparam logic [3:0] REG_WA_HOUR = 4'h9;
  localparam logic [3:0] REG_WA_WDAY = 4'ha;
  localparam logic [3:0] REG_DA_MIN = 4'hb;
  localparam logic [3:0] REG_DA_HOUR = 4'hc;
  localparam logic [3:0] REG_HOLE = 4'hd;
  localparam logic [3:0] REG_CTRL1 = 4'he;
  localparam logic [3:0] REG_CTRL2 = 4'hf;
  localparam int unsigned APB_IDX_LSB = 2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CENT_BIT = 7;
  localparam int unsigned PM_BIT = 5;
  localparam int unsigned WALE_BIT = 7;
  localparam int unsigned DALE_BIT = 6;
  localparam int unsigned H24_BIT = 5;
  localparam int unsigned WAFG_BIT = 1;
  localparam int unsigned DAFG_BIT = 0;

  // ----------------------------------------------------------------
  // writable bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_MINSEC = 8'h7f;
  localparam logic [7:0] MASK_HOUR = 8'h3f;
  localparam logic [7:0] MASK_WDAY = 8'h07;
  localparam logic [7:0] MASK_DAY = 8'h3f;
  localparam logic [7:0] MASK_MON = 8'h1f;
  localparam logic [7:0] MASK_WSET = 8'h7f;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_HOUR = 8'h12;
  localparam logic [7:0] RST_ONE = 8'h01;

endpackage

`default_nettype wire

// >>> rtc_i2c_slave.sv
`default_nettype none

module rtc_i2c_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [3:0] reg_idx,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);

  typedef enum {ST_IDLE, ST_ADDR, ST_ACK_A, ST_WDATA, ST_ACK_W, ST_RDATA, ST_ACK_R} rtc_i2c_e;

  rtc_i2c_e state;
  logic [1:0] s1, s2, filt, filt_q;
  logic [1:0] fcnt [2];
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic first_byte;
  logic scl, sda, scl_rise, scl_fall, start, stop;

  // ----------------------------------------------------------------
  // sync and spike filter on both lines
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      filt <= 2'h3;
      filt_q <= 2'h3;
      fcnt[0] <= 2'h0;
      fcnt[1] <= 2'h0;
    end else begin
      s1 <= {scl_in, sda_in};
      s2 <= s1;
      filt_q <= filt;
      for (int i = 0; i < 2; i++) begin
        if (s2[i] == filt[i]) begin
          fcnt[i] <= 2'h0;
        end else if (fcnt[i] == 2'(rtc_pkg::FILT_CYC)) begin
          filt[i] <= s2[i];
          fcnt[i] <= 2'h0;
        end else begin
          fcnt[i] <= fcnt[i] + 2'h1;
        end
      end
    end
  end

  assign scl = filt[1];
  assign sda = filt[0];
  assign scl_rise = scl & ~filt_q[1];
  assign scl_fall = ~scl & filt_q[1];
  assign start = scl & filt_q[1] & filt_q[0] & ~sda;
  assign stop = scl & filt_q[1] & ~filt_q[0] & sda;
  assign sda_out = 1'b0;
  assign reg_wdata = shreg;

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      first_byte <= 1'b0;
      sda_oe <= 1'b0;
      reg_idx <= 4'h0;
      reg_wr <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      if (start) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_WDATA: begin
            if (scl_rise && bitcnt != 4'h8) begin
              shreg <= {shreg[6:0], sda};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (state == ST_WDATA) begin
                sda_oe <= 1'b1;
                state <= ST_ACK_W;
                if (first_byte) begin
                  reg_idx <= shreg[3:0];
                end else begin
                  reg_wr <= 1'b1;
                end
              end else if (shreg[7:1] == rtc_pkg::I2C_ADDR) begin
                sda_oe <= 1'b1;
                state <= ST_ACK_A;
                first_byte <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK_A: begin
            if (scl_fall) begin
              if (shreg[0]) begin
                shreg <= reg_rdata;
                sda_oe <= ~reg_rdata[7];
                reg_idx <= reg_idx + 4'h1;
                bitcnt <= 4'h1;
                state <= ST_RDATA;
              end else begin
                sda_oe <= 1'b0;
                state <= ST_WDATA;
              end
            end
          end
          ST_ACK_W: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              if (!first_byte) begin
                reg_idx <= reg_idx + 4'h1;
              end
              first_byte <= 1'b0;
              state <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe <= 1'b0;
                state <= ST_ACK_R;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          ST_ACK_R: begin
            if (scl_rise && sda) begin
              state <= ST_IDLE;
            end else if (scl_fall) begin
              shreg <= reg_rdata;
              sda_oe <= ~reg_rdata[7];
              reg_idx <= reg_idx + 4'h1;
              bitcnt <= 4'h1;
              state <= ST_RDATA;
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // rtc_i2c_slave

`default_nettype wire

// >>> rtc_core.sv
// Local design decisions: the address map and register access over APB.
`default_nettype none

module rtc_core #(
  parameter int unsigned OSC_HZ = rtc_pkg::OSC_HZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_clk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic weekly_alarm_irq_n,
  output logic daily_alarm_irq_n
);

  logic [7:0] sec, min, hour, wday, day, mon, year;
  logic cent;
  logic [7:0] adj, wa_min, wa_hour, wa_wday, da_min, da_hour, ctrl1, ctrl2;
  logic wafg, dafg;
  logic [7:0] next_sec, next_min, next_hour, next_wday, next_day, next_mon, next_year;
  logic next_cent;
  logic [3:0] i2c_idx;
  logic i2c_wr;
  logic [7:0] i2c_wdata, i2c_rdata;
  logic apb_wr, wr_en;
  logic [3:0] apb_idx, wr_idx;
  logic [7:0] wr_data;
  logic apb_hit;
  logic leap, tick, h24;
  logic wmatch, dmatch, wmatch_q, dmatch_q;
  logic [1:0] osc_rst_sync;
  logic [31:0] osc_cnt;
  logic sec_tgl;
  logic [2:0] tgl_sync;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function automatic logic div4(input logic [7:0] y);
    if (y[4]) begin
      div4 = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      div4 = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m, input logic lp);
    case (m)
      8'h02: last_day = lp ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction

  function automatic logic [7:0] rd_reg(input logic [3:0] idx);
    case (idx)
      rtc_pkg::REG_SEC: rd_reg = sec;
      rtc_pkg::REG_MIN: rd_reg = min;
      rtc_pkg::REG_HOUR: rd_reg = hour;
      rtc_pkg::REG_WDAY: rd_reg = wday;
      rtc_pkg::REG_DAY: rd_reg = day;
      rtc_pkg::REG_MON: rd_reg = {cent, mon[6:0]};
      rtc_pkg::REG_YEAR: rd_reg = year;
      rtc_pkg::REG_ADJ: rd_reg = adj;
      rtc_pkg::REG_WA_MIN: rd_reg = wa_min;
      rtc_pkg::REG_WA_HOUR: rd_reg = wa_hour;
      rtc_pkg::REG_WA_WDAY: rd_reg = wa_wday;
      rtc_pkg::REG_DA_MIN: rd_reg = da_min;
      rtc_pkg::REG_DA_HOUR: rd_reg = da_hour;
      rtc_pkg::REG_CTRL1: rd_reg = ctrl1;
      rtc_pkg::REG_CTRL2: rd_reg = {ctrl2[7:2], wafg, dafg};
      default: rd_reg = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // oscillator domain: one-second toggle
  // ----------------------------------------------------------------
  always_ff @(posedge osc_clk) begin
    osc_rst_sync <= {osc_rst_sync[0], rst};
  end

  always_ff @(posedge osc_clk) begin
    if (osc_rst_sync[1]) begin
      osc_cnt <= 32'h0;
      sec_tgl <= 1'b0;
    end else if (osc_cnt == 32'(OSC_HZ - 1)) begin
      osc_cnt <= 32'h0;
      sec_tgl <= ~sec_tgl;
    end else begin
      osc_cnt <= osc_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // toggle crossing into the bus clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tgl_sync <= 3'h0;
    end else begin
      tgl_sync <= {tgl_sync[1:0], sec_tgl};
    end
  end

  assign tick = tgl_sync[2] ^ tgl_sync[1];

  // ----------------------------------------------------------------
  // serial bus slave
  // ----------------------------------------------------------------
  rtc_i2c_slave u_i2c (
    .clk(clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_idx(i2c_idx),
    .reg_wr(i2c_wr),
    .reg_wdata(i2c_wdata),
    .reg_rdata(i2c_rdata)
  );

  assign i2c_rdata = rd_reg(i2c_idx);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign apb_idx = paddr[rtc_pkg::APB_IDX_LSB +: 4];
  assign apb_hit = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0)
                   && (apb_idx != rtc_pkg::REG_HOLE);
  assign pready = ~i2c_wr;
  assign apb_wr = psel & penable & pwrite & pready & apb_hit;
  assign wr_en = apb_wr | i2c_wr;
  assign wr_idx = i2c_wr ? i2c_idx : apb_idx;
  assign wr_data = i2c_wr ? i2c_wdata : pwdata[7:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= apb_hit ? {24'h0, rd_reg(apb_idx)} : 32'h0;
      pslverr <= ~apb_hit;
    end
  end

  // ----------------------------------------------------------------
  // carry chain
  // ----------------------------------------------------------------
  assign h24 = ctrl1[rtc_pkg::H24_BIT];
  assign leap = div4(year) && ((year != 8'h00) || cent);

  always_comb begin
    next_sec = sec;
    next_min = min;
    next_hour = hour;
    next_wday = wday;
    next_day = day;
    next_mon = mon;
    next_year = year;
    next_cent = cent;
    if (tick) begin
      next_sec = bcd_inc(sec);
      if (sec == 8'h59) begin
        next_sec = 8'h00;
        next_min = bcd_inc(min);
        if (min == 8'h59) begin
          next_min = 8'h00;
          if (h24) begin
            next_hour = (hour == 8'h23) ? 8'h00 : bcd_inc(hour);
          end else if (hour[4:0] == 5'h11) begin
            next_hour = {2'h0, ~hour[rtc_pkg::PM_BIT], 5'h12};
          end else if (hour[4:0] == 5'h12) begin
            next_hour = {2'h0, hour[rtc_pkg::PM_BIT], 5'h01};
          end else begin
            next_hour = {2'h0, hour[rtc_pkg::PM_BIT], 5'(bcd_inc({3'h0, hour[4:0]}))};
          end
          if (h24 ? (hour == 8'h23) : (hour == 8'h31)) begin
            next_wday = (wday == 8'h06) ? 8'h00 : wday + 8'h01;
            next_day = bcd_inc(day);
            if (day == last_day(mon, leap)) begin
              next_day = 8'h01;
              next_mon = bcd_inc(mon);
              if (mon == 8'h12) begin
                next_mon = 8'h01;
                next_year = bcd_inc(year);
                if (year == 8'h99) begin
                  next_year = 8'h00;
                  next_cent = ~cent;
                end
              end
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // time and date registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sec <= rtc_pkg::RST_ZERO;
      min <= rtc_pkg::RST_ZERO;
      hour <= rtc_pkg::RST_HOUR;
      wday <= rtc_pkg::RST_ZERO;
      day <= rtc_pkg::RST_ONE;
      mon <= rtc_pkg::RST_ONE;
      year <= rtc_pkg::RST_ZERO;
      cent <= 1'b0;
    end else begin
      sec <= next_sec;
      min <= next_min;
      hour <= next_hour;
      wday <= next_wday;
      day <= next_day;
      mon <= next_mon;
      year <= next_year;
      cent <= next_cent;
      if (wr_en) begin
        case (wr_idx)
          rtc_pkg::REG_SEC: sec <= wr_data & rtc_pkg::MASK_MINSEC;
          rtc_pkg::REG_MIN: min <= wr_data & rtc_pkg::MASK_MINSEC;
          rtc_pkg::REG_HOUR: hour <= wr_data & rtc_pkg::MASK_HOUR;
          rtc_pkg::REG_WDAY: wday <= wr_data & rtc_pkg::MASK_WDAY;
          rtc_pkg::REG_DAY: day <= wr_data & rtc_pkg::MASK_DAY;
          rtc_pkg::REG_MON: begin
            mon <= wr_data & rtc_pkg::MASK_MON;
            cent <= wr_data[rtc_pkg::CENT_BIT];
          end
          rtc_pkg::REG_YEAR: year <= wr_data;
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // alarm and control settings
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      adj <= rtc_pkg::RST_ZERO;
      wa_min <= rtc_pkg::RST_ZERO;
      wa_hour <= rtc_pkg::RST_ZERO;
      wa_wday <= rtc_pkg::RST_ZERO;
      da_min <= rtc_pkg::RST_ZERO;
      da_hour <= rtc_pkg::RST_ZERO;
      ctrl1 <= rtc_pkg::RST_ZERO;
      ctrl2 <= rtc_pkg::RST_ZERO;
    end else if (wr_en) begin
      case (wr_idx)
        rtc_pkg::REG_ADJ: adj <= wr_data & rtc_pkg::MASK_WSET;
        rtc_pkg::REG_WA_MIN: wa_min <= wr_data & rtc_pkg::MASK_MINSEC;
        rtc_pkg::REG_WA_HOUR: wa_hour <= wr_data & rtc_pkg::MASK_HOUR;
        rtc_pkg::REG_WA_WDAY: wa_wday <= wr_data & rtc_pkg::MASK_WSET;
        rtc_pkg::REG_DA_MIN: da_min <= wr_data & rtc_pkg::MASK_MINSEC;
        rtc_pkg::REG_DA_HOUR: da_hour <= wr_data & rtc_pkg::MASK_HOUR;
        rtc_pkg::REG_CTRL1: ctrl1 <= wr_data;
        rtc_pkg::REG_CTRL2: ctrl2 <= {wr_data[7:2], 2'h0};
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // alarm compare
  // ----------------------------------------------------------------
  assign wmatch = (min == wa_min) && (hour == wa_hour) && (wday < 8'h07)
                  && wa_wday[wday[2:0]];
  assign dmatch = (min == da_min) && (hour == da_hour);

  always_ff @(posedge clk) begin
    if (rst) begin
      wmatch_q <= 1'b0;
      dmatch_q <= 1'b0;
    end else begin
      wmatch_q <= wmatch;
      dmatch_q <= dmatch;
    end
  end

  // ----------------------------------------------------------------
  // alarm flags, set beats clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      wafg <= 1'b0;
      dafg <= 1'b0;
    end else begin
      if (wr_en && wr_idx == rtc_pkg::REG_CTRL2) begin
        wafg <= wafg & wr_data[rtc_pkg::WAFG_BIT];
        dafg <= dafg & wr_data[rtc_pkg::DAFG_BIT];
      end
      if (wmatch && !wmatch_q && ctrl1[rtc_pkg::WALE_BIT]) begin
        wafg <= 1'b1;
      end
      if (dmatch && !dmatch_q && ctrl1[rtc_pkg::DALE_BIT]) begin
        dafg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      weekly_alarm_irq_n <= 1'b1;
      daily_alarm_irq_n <= 1'b1;
    end else begin
      weekly_alarm_irq_n <= ~(wafg & ctrl1[rtc_pkg::WALE_BIT]);
      daily_alarm_irq_n <= ~(dafg & ctrl1[rtc_pkg::DALE_BIT]);
    end
  end

endmodule // rtc_core

`default_nettype wire

// >>> rtc_core_props.sv
`default_nettype none
module rtc_core_props #(
  parameter int unsigned OSC_HZ = rtc_pkg::OSC_HZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_clk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic weekly_alarm_irq_n,
  input wire logic daily_alarm_irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // bus and pin checks
  // ----
  logic setup;
  logic rd_flags;
  logic any_wr, wirq;
  assign setup = psel && !penable;
  assign any_wr = (psel && pwrite) || !pready;
  assign wirq = !weekly_alarm_irq_n;
  assign rd_flags = setup && !pwrite && paddr == 32'h3c;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sda_low_only_a: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  irq_reset_a: assert property ($fell(rst) |-> weekly_alarm_irq_n && daily_alarm_irq_n)
    else $error("irq active after reset");
  hole_err_a: assert property (setup && paddr[5:2] == 4'hd |=> pslverr && prdata == 0)
    else $error("hole access not refused");
  misalign_a: assert property (setup && paddr[1:0] != 2'b00 |=> pslverr)
    else $error("misaligned access not refused");
  upper_zero_a: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  wflag_mirror_a: assert property (rd_flags |=> weekly_alarm_irq_n || prdata[1])
    else $error("weekly flag differs from pin");
  dflag_mirror_a: assert property (rd_flags |=> daily_alarm_irq_n || prdata[0])
    else $error("daily flag differs from pin");
  apb_wait_a: assert property (psel && penable |-> ##[0:4] pready)
    else $error("access not answered");
  wirq_hold_a: assert property (wirq && !$past(any_wr) |=> wirq)
    else $error("weekly irq dropped by itself");
  cover property ($fell(daily_alarm_irq_n));
  cover property ($fell(weekly_alarm_irq_n));
  cover property (setup ##1 pslverr);
  cover property ($rose(sda_oe));
endmodule // rtc_core_props
`default_nettype wire

// >>> rtc_i2c_host.sv
`default_nettype none
module rtc_i2c_host (
  output logic scl,
  output logic pull,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // host side, clock still outside frames
  // ----
  localparam int HALF = 1250;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic start();
    pull = 1'b0;
    #HALF;
    scl = 1'b1;
    #HALF;
    pull = 1'b1;
    #HALF;
    scl = 1'b0;
    #(HALF / 4);
  endtask
  task automatic stop();
    pull = 1'b1;
    #HALF;
    scl = 1'b1;
    #HALF;
    pull = 1'b0;
    #HALF;
  endtask
  task automatic spike();
    scl = 1'b1;
    #50;
    scl = 1'b0;
    #HALF;
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      pull = !d[i];
      #HALF;
      scl = 1'b1;
      #(HALF / 2);
      q[i] = sda;
      #(HALF / 2);
      scl = 1'b0;
      #(HALF / 4);
    end
  endtask
endmodule // rtc_i2c_host
`default_nettype wire

// >>> rtc_core_tb.sv
`default_nettype none
module rtc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned OSC_HZ = 128;
  localparam int SEC_CYC = OSC_HZ * 15 / 40 + 1;
  logic clk = 1'b0;
  logic osc_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, irqs;
  logic pready, pslverr, sda_out, sda_oe, weekly_alarm_irq_n, daily_alarm_irq_n, e, scl, pull;
  logic [8:0] r;
  logic [7:0] d;
  wire logic sda;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 32'h236b2e71;
  int wset, y, m, dd, dim;
  int yr[4] = '{4, 1, 99, 3};
  int mo[4] = '{2, 2, 12, 4};
  int dy[4] = '{28, 28, 31, 30};
  assign sda = !(pull || sda_oe);
  assign irqs = {30'h0, weekly_alarm_irq_n, daily_alarm_irq_n};
  always #20 clk = !clk;
  always #7.5 osc_clk = !osc_clk;
  rtc_core #(.OSC_HZ(OSC_HZ)) dut (.clk(clk), .rst(rst), .osc_clk(osc_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .weekly_alarm_irq_n(weekly_alarm_irq_n),
    .daily_alarm_irq_n(daily_alarm_irq_n));
  rtc_i2c_host host (.scl(scl), .pull(pull), .sda(sda));
  // ----
  // bus tasks and model
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] v);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {26'h0, i, 2'b00};
    pwdata <= {24'h0, v};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] v);
    apb(1'b1, i, v);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] v);
    apb(1'b0, i, 8'h00);
    chk(q, {24'h0, v});
  endtask
  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #2ms;
    num_errors++;
    tally_and_finish();
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(rtc_pkg::REG_HOUR, 8'h12);
    rd(rtc_pkg::REG_DAY, 8'h01);
    rd(rtc_pkg::REG_CTRL2, 8'h00);
    chk(irqs, 32'h3);
    for (int i = 8; i < 13; i++) begin
      d = 8'($random(seed));
      wr(4'(i), d);
      rd(4'(i), d & ((i == 9 || i == 12) ? rtc_pkg::MASK_HOUR : rtc_pkg::MASK_MINSEC));
    end
    wr(rtc_pkg::REG_HOLE, 8'hff);
    apb(1'b0, rtc_pkg::REG_HOLE, 8'h00);
    chk({q[30:0], e}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(rtc_pkg::REG_CTRL1, (i == 1) ? 8'h00 : 8'h20);
      y = yr[i];
      m = mo[i];
      dd = dy[i];
      wr(rtc_pkg::REG_SEC, 8'h00);
      wr(rtc_pkg::REG_YEAR, bcd(y));
      wr(rtc_pkg::REG_MON, bcd(m));
      wr(rtc_pkg::REG_DAY, bcd(dd));
      wr(rtc_pkg::REG_HOUR, (i == 1) ? 8'h31 : 8'h23);
      wr(rtc_pkg::REG_MIN, 8'h59);
      wr(rtc_pkg::REG_SEC, 8'h58);
      repeat (4 * SEC_CYC) @(posedge clk);
      dim = (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
      dim = (m == 2) ? ((y % 4 == 0) ? 29 : 28) : dim;
      dd = (dd < dim) ? dd + 1 : 1;
      m = (dd > 1) ? m : m % 12 + 1;
      y = (dd == 1 && m == 1) ? (y + 1) % 100 : y;
      rd(rtc_pkg::REG_DAY, bcd(dd));
      rd(rtc_pkg::REG_MON, bcd(m) | ((y < yr[i]) ? 8'h80 : 8'h00));
      rd(rtc_pkg::REG_YEAR, bcd(y));
      rd(rtc_pkg::REG_HOUR, (i == 1) ? 8'h12 : 8'h00);
    end
    for (int i = 0; i < 7; i++) begin
      wset = $random(seed);
      wr(rtc_pkg::REG_SEC, 8'h00);
      wr(rtc_pkg::REG_MIN, 8'h00);
      wr(rtc_pkg::REG_HOUR, 8'h10);
      wr(rtc_pkg::REG_WDAY, 8'(i));
      wr(rtc_pkg::REG_WA_WDAY, 8'(wset));
      wr(rtc_pkg::REG_WA_MIN, 8'h01);
      wr(rtc_pkg::REG_WA_HOUR, 8'h10);
      wr(rtc_pkg::REG_DA_MIN, 8'h01);
      wr(rtc_pkg::REG_DA_HOUR, 8'h10);
      wr(rtc_pkg::REG_CTRL2, 8'h00);
      wr(rtc_pkg::REG_CTRL1, 8'he0);
      wr(rtc_pkg::REG_SEC, 8'h58);
      repeat (4 * SEC_CYC) @(posedge clk);
      chk(irqs, {30'h0, !wset[i], 1'b0});
      rd(rtc_pkg::REG_CTRL2, {6'h0, 1'(wset[i]), 1'b1});
      repeat (20) @(posedge clk);
      chk(irqs, {30'h0, !wset[i], 1'b0});
      wr(rtc_pkg::REG_CTRL2, 8'h00);
      repeat (3) @(posedge clk);
      chk(irqs, 32'h3);
    end
    host.start();
    host.spike();
    host.xfer({rtc_pkg::I2C_ADDR, 2'b01}, r);
    host.stop();
    chk({31'h0, r[0]}, 32'h0);
    d = 8'($random(seed));
    host.start();
    host.xfer({rtc_pkg::I2C_ADDR, 2'b01}, r);
    chk({31'h0, r[0]}, 32'h0);
    host.xfer({4'h0, rtc_pkg::REG_DA_MIN, 1'b1}, r);
    host.xfer({d, 1'b1}, r);
    host.xfer({8'h17, 1'b1}, r);
    host.stop();
    rd(rtc_pkg::REG_DA_MIN, d & rtc_pkg::MASK_MINSEC);
    rd(rtc_pkg::REG_DA_HOUR, 8'h17);
    host.start();
    host.xfer({rtc_pkg::I2C_ADDR, 2'b01}, r);
    host.xfer({4'h0, rtc_pkg::REG_DA_MIN, 1'b1}, r);
    host.start();
    host.xfer({rtc_pkg::I2C_ADDR, 2'b11}, r);
    host.xfer(9'h1ff, r);
    host.stop();
    chk({24'h0, r[8:1]}, {24'h0, d & rtc_pkg::MASK_MINSEC});
    host.start();
    host.xfer({~rtc_pkg::I2C_ADDR, 2'b01}, r);
    host.stop();
    chk({31'h0, r[0]}, 32'h1);
    tally_and_finish();
  end
endmodule // rtc_core_tb
bind rtc_core rtc_core_props #(.OSC_HZ(OSC_HZ)) u_props (.clk(clk), .rst(rst),
  .osc_clk(osc_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .weekly_alarm_irq_n(weekly_alarm_irq_n), .daily_alarm_irq_n(daily_alarm_irq_n));
`default_nettype wire
